// File: hw/twi_pkg.sv
// Shared constants and types for the two-wire serial master
package twi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS      = 4;
  localparam int STD_BIT_NS  = 10000;
  localparam int FAST_BIT_NS = 2500;
  localparam int QTR_W       = 12;
  // Each bit is four quarters; a least time, so round up
  localparam int QTR_STD_CYC  = (STD_BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
  localparam int QTR_FAST_CYC = (FAST_BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Bit phases and byte framing
  localparam logic [1:0] Q_FIRST  = 2'h0;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_LAST   = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] RX_IDLE  = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic SCL_RST      = 1'b1;
  localparam logic SDA_OE_RST   = 1'b0;
  localparam logic BUS_FREE_RST = 1'b1;
  localparam logic SYNC_RST     = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Commands and states
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ  = 2'h2,
    CMD_STOP  = 2'h3
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_BITS  = 3'h3,
    ST_ACK   = 3'h2,
    ST_STOP  = 3'h6
  } state_t;

endpackage

// File: hw/twi_sync2.sv
// Two-flop synchroniser for the serial data pin
`timescale 1ns/1ps
module twi_sync2 (
  // Clock and reset
  input  logic i_ref_clk,
  input  logic i_sys_rst,
  // Pin and synchronised level
  input  logic i_async,
  output logic o_sync
);
  import twi_pkg::*;

  logic meta_r;
  logic sync_r;

  // Only the second flop reads the first
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      meta_r <= SYNC_RST;
      sync_r <= SYNC_RST;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule

// File: hw/twi_quarter_div.sv
// Quarter-bit tick divider with selectable bit rate
`timescale 1ns/1ps
module twi_quarter_div #(
  parameter int QTR_STD  = twi_pkg::QTR_STD_CYC,
  parameter int QTR_FAST = twi_pkg::QTR_FAST_CYC
) (
  // Clock and reset
  input  logic i_ref_clk,
  input  logic i_sys_rst,
  // Control
  input  logic i_restart,
  input  logic i_fast,
  // Tick
  output logic o_tick
);
  import twi_pkg::*;

  logic [QTR_W-1:0] cnt_r;
  logic [QTR_W-1:0] cnt_nxt;
  logic [QTR_W-1:0] lim_w;

  ////////////////////////////////////////////////////////////////////////////
  // Rate select and count
  assign lim_w   = i_fast ? QTR_W'(QTR_FAST - 1) : QTR_W'(QTR_STD - 1);
  assign o_tick  = !i_restart && (cnt_r == lim_w);
  assign cnt_nxt = (i_restart || o_tick) ? '0 : cnt_r + QTR_W'(1);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_quarter_wrap: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_tick |=> (cnt_r == '0))
    else $error("quarter counter did not wrap after tick");

  a_rate_bound: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !i_restart |-> (cnt_r <= lim_w))
    else $error("quarter counter ran past selected rate");

endmodule

// File: hw/twi_master.sv
// Master-only two-wire serial interface engine
// Operation
// - Runs standard or fast bit rate
// - Single master, no arbitration or stretching
// - Clock line is output only
// - Data line is open drain
// - Bytes go MSB first, one bit per clock
// - Receiver acknowledges in following clock period
// - Data changes only while clock is low
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Master acknowledges by pulling data low
// - Master not taking byte leaves data undriven
// - Write opens with address, direction zero
// - Memory address then data, stop ends
// - Read uses repeated start, direction one
// - Last read byte gets nack then stop
// - Acknowledge all read bytes except last
`timescale 1ns/1ps
module twi_master #(
  parameter int QTR_STD  = twi_pkg::QTR_STD_CYC,
  parameter int QTR_FAST = twi_pkg::QTR_FAST_CYC
) (
  // Clock and reset
  input  logic              i_ref_clk,
  input  logic              i_sys_rst,
  // Configuration
  input  logic              i_fast,
  // Command
  input  logic              i_cmd_valid,
  input  twi_pkg::cmd_t     i_cmd_code,
  input  logic [7:0]        i_cmd_wdata,
  input  logic              i_cmd_nack,
  output logic              o_cmd_ready,
  // Response
  output logic              o_rsp_valid,
  output logic [7:0]        o_rsp_data,
  output logic              o_rsp_nack,
  // Status
  output logic              o_bus_free,
  // Serial pins
  output logic              o_scl,
  output logic              o_sda_o,
  output logic              o_sda_oe,
  input  logic              i_sda_i
);
  import twi_pkg::*;

  state_t     st_r;
  state_t     st_nxt;
  state_t     lag_st_r;
  logic [1:0] q_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic       rx_r;
  logic       is_read_r;
  logic       nack_r;
  logic       bus_free_r;
  logic       fast_r;
  logic       scl_r;
  logic       oe_r;
  logic       rsp_valid_r;
  logic [7:0] rsp_data_r;
  logic       rsp_nack_r;

  logic       tick;
  logic       sda_s;
  logic       accept;
  logic       q_end;
  logic       sample;
  logic       in_idle;
  logic       in_start;
  logic       in_bits;
  logic       in_ack;
  logic       in_stop;
  logic       scl_start_stop;
  logic       scl_data;
  logic       scl_want;
  logic       oe_start;
  logic       oe_stop;
  logic       oe_bits;
  logic       oe_ack;
  logic       oe_want;
  logic       byte_done;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  twi_quarter_div #(
    .QTR_STD  (QTR_STD),
    .QTR_FAST (QTR_FAST)
  ) u_div (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_restart (in_idle),
    .i_fast    (fast_r),
    .o_tick    (tick)
  );

  twi_sync2 u_sync (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_sda_i),
    .o_sync    (sda_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  assign in_idle   = (st_r == ST_IDLE);
  assign in_start  = (st_r == ST_START);
  assign in_bits   = (st_r == ST_BITS);
  assign in_ack    = (st_r == ST_ACK);
  assign in_stop   = (st_r == ST_STOP);
  assign accept    = i_cmd_valid && in_idle;
  assign q_end     = tick && (q_r == Q_LAST);
  assign sample    = tick && (q_r == Q_SAMPLE);
  assign byte_done = in_bits && q_end && (bit_r == BIT_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Line levels per quarter
  // Start and stop hold the clock high from the second quarter on
  assign scl_start_stop = (q_r != Q_FIRST);
  // Data bits: low, high, high (sample), low
  assign scl_data       = (q_r == 2'h1) || (q_r == Q_SAMPLE);
  // Clock is never read back, so a slave cannot stretch or contest it
  assign scl_want       = in_idle ? bus_free_r :
                          (in_start || in_stop) ? scl_start_stop : scl_data;

  // Released in the first half, pulled low while the clock is high
  assign oe_start = q_r[1];
  // Pulled low in the first half, released while the clock is high
  assign oe_stop  = !q_r[1];
  // Read bytes leave the line to the slave
  assign oe_bits  = !is_read_r && !sh_r[7];
  // On write the slave answers; on read we pull low unless refusing
  assign oe_ack   = is_read_r && !nack_r;
  // Idle keeps the line as left, so data never moves as the clock falls after a start
  assign oe_want  = in_start ? oe_start :
                    in_stop  ? oe_stop  :
                    in_bits  ? oe_bits  :
                    in_ack   ? oe_ack   : oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (i_cmd_valid) begin
          case (i_cmd_code)
            CMD_START: st_nxt = ST_START;
            // Address, memory address and data bytes all go out this way
            CMD_WRITE: st_nxt = ST_BITS;
            CMD_READ:  st_nxt = ST_BITS;
            CMD_STOP:  st_nxt = ST_STOP;
            default:   st_nxt = ST_IDLE;
          endcase
        end
      end
      ST_START: begin
        if (q_end) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_BITS: begin
        if (byte_done) begin
          st_nxt = ST_ACK;
        end
      end
      ST_ACK: begin
        if (q_end) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_STOP: begin
        if (q_end) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_r     <= ST_IDLE;
      lag_st_r <= ST_IDLE;
    end else begin
      st_r     <= st_nxt;
      lag_st_r <= st_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter and bit counters
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || in_idle) begin
      q_r <= Q_FIRST;
    end else if (tick) begin
      q_r <= q_r + 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || accept) begin
      bit_r <= 3'h0;
    end else if (in_bits && q_end) begin
      bit_r <= bit_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and captured line
  // One register serves both directions: it shifts left at each bit end
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sh_r <= RX_IDLE;
    end else if (accept) begin
      sh_r <= (i_cmd_code == CMD_READ) ? RX_IDLE : i_cmd_wdata;
    end else if (in_bits && q_end) begin
      sh_r <= {sh_r[6:0], rx_r};
    end
  end

  // Sampled at the end of the high phase, well after the synchroniser delay settles
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rx_r <= 1'b1;
    end else if (sample) begin
      rx_r <= sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-command settings
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      is_read_r <= 1'b0;
      nack_r    <= 1'b0;
      fast_r    <= 1'b0;
    end else if (accept) begin
      is_read_r <= (i_cmd_code == CMD_READ);
      nack_r    <= i_cmd_nack;
      fast_r    <= i_fast;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      bus_free_r <= BUS_FREE_RST;
    end else if (in_start && q_end) begin
      bus_free_r <= 1'b0;
    end else if (in_stop && q_end) begin
      bus_free_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= 8'h00;
      rsp_nack_r  <= 1'b0;
    end else begin
      rsp_valid_r <= in_ack && q_end;
      if (in_ack && q_end) begin
        rsp_data_r <= sh_r;
        rsp_nack_r <= is_read_r ? nack_r : rx_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  // Outputs are registered so both lines move on the same edge
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      scl_r <= SCL_RST;
      oe_r  <= SDA_OE_RST;
    end else begin
      scl_r <= scl_want;
      oe_r  <= oe_want;
    end
  end

  assign o_scl       = scl_r;
  assign o_sda_o     = 1'b0;
  assign o_sda_oe    = oe_r;
  assign o_cmd_ready = in_idle;
  assign o_rsp_valid = rsp_valid_r;
  assign o_rsp_data  = rsp_data_r;
  assign o_rsp_nack  = rsp_nack_r;
  assign o_bus_free  = bus_free_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_stop_end;
    tick && in_stop && (q_r == Q_LAST);
  endsequence

  sequence s_bus_released;
    ##1 in_idle ##1 (o_scl && !o_sda_oe && o_bus_free);
  endsequence

  property p_stop_frees;
    s_stop_end |-> s_bus_released;
  endproperty

  a_data_stable_high: assert property (
    ($changed(o_sda_oe) && o_scl && $past(o_scl)) |-> (lag_st_r == ST_START || lag_st_r == ST_STOP))
    else $error("data line moved while clock high outside start or stop");

  a_start_edge: assert property (
    ($rose(o_sda_oe) && o_scl && $past(o_scl)) |-> (lag_st_r == ST_START))
    else $error("data fell under high clock without a start");

  a_stop_edge: assert property (
    ($fell(o_sda_oe) && o_scl && $past(o_scl)) |-> (lag_st_r == ST_STOP))
    else $error("data rose under high clock without a stop");

  a_stop_frees_bus: assert property (p_stop_frees)
    else $error("bus not released after stop");

  a_msb_first: assert property (
    (accept && i_cmd_code == CMD_WRITE) |-> ##2 (o_sda_oe == !$past(i_cmd_wdata[7], 2)))
    else $error("first bit out is not the most significant");

  a_master_ack: assert property (
    (in_ack && is_read_r && !nack_r) |=> o_sda_oe)
    else $error("master did not acknowledge read byte");

  a_master_nack: assert property (
    (in_ack && is_read_r && nack_r) |=> !o_sda_oe)
    else $error("master drove data when refusing byte");

  a_read_release: assert property (
    (sample && in_ack && is_read_r && nack_r) |=> rx_r)
    else $error("slave held data low in acknowledge slot");

  a_read_quiet: assert property (
    (in_bits && is_read_r) |=> !o_sda_oe)
    else $error("master drove data while slave sends");

  a_write_ack_free: assert property (
    (in_ack && !is_read_r) |=> !o_sda_oe)
    else $error("master drove data in slave acknowledge slot");

  a_rsp_after_ack: assert property (
    o_rsp_valid |-> ($past(st_r) == ST_ACK && in_idle))
    else $error("response without acknowledge slot");

  a_scl_low_idle_busy: assert property (
    (in_idle && !bus_free_r) |=> !o_scl)
    else $error("clock not parked low inside a transfer");

endmodule

// File: dv/twi_slave_model.sv
// Behavioural two-wire serial slave with a byte memory
`timescale 1ns/1ps
module twi_slave_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  // Bus
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_pull
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [7:0] tx;
  logic       active   = 1'b0;
  logic       sending  = 1'b0;
  logic       go       = 1'b0;
  logic       rd       = 1'b0;
  logic       ok       = 1'b0;
  logic       ack_seen = 1'b0;
  logic       nxt;
  int         bit_n    = 0;
  int         byte_n   = 0;

  initial o_pull = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Start and stop seen on the wire
  always @(negedge i_sda) if (i_scl === 1'b1) begin
    active = 1'b1;
    bit_n = 0;
    byte_n = 0;
    sending = 1'b0;
    go = 1'b0;
    o_pull = 1'b0;
  end
  always @(posedge i_sda) if (i_scl === 1'b1) active = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Bits are sampled while the clock is high
  always @(posedge i_scl) if (active) begin
    if (bit_n < 8) begin
      sh = {sh[6:0], i_sda};
    end else if (sending) begin
      ack_seen = i_sda;
      go = ~i_sda;
      sending = 1'b0;
    end
    bit_n = (bit_n == 8) ? 0 : bit_n + 1;
  end

  // Drive only just after the clock falls; one assignment so no glitch
  always @(negedge i_scl) if (active) begin
    nxt = 1'b0;
    if (bit_n == 8 && !sending) begin
      if (byte_n == 0) begin
        ok = (sh[7:1] == DEV_ADDR);
        rd = sh[0];
        go = ok && sh[0];
      end else if (ok && !rd && byte_n == 1) begin
        ptr = sh;
      end else if (ok && !rd) begin
        mem[ptr] = sh;
        ptr++;
      end
      byte_n++;
      nxt = ok;
    end else if (bit_n == 0 && go) begin
      tx = mem[ptr];
      ptr++;
      sending = 1'b1;
      go = 1'b0;
      nxt = ~tx[7];
    end else if (sending && bit_n < 8) begin
      nxt = ~tx[7 - bit_n];
    end
    // Left released in the acknowledge bit while sending
    o_pull = nxt;
  end
endmodule

// File: dv/two_wire_serial_master_tb.sv
// Self-checking bench for the two-wire serial master
`timescale 1ns/1ps
module two_wire_serial_master_tb;
  import twi_pkg::*;
  // Short quarters keep the run brief; expectations derive from these
  localparam int         QS  = 5;
  localparam int         QF  = 3;
  localparam logic [6:0] DEV = 7'h50;

  logic       i_ref_clk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       fast      = 1'b0;
  logic       valid     = 1'b0;
  cmd_t       code      = CMD_START;
  logic [7:0] wdata     = 8'h00;
  logic       nack      = 1'b0;
  logic       ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_nack;
  logic       bus_free;
  logic       scl;
  logic       sda_o;
  logic       sda_oe;
  logic       pull;
  logic       scl_q     = 1'b1;
  wire        sda_w;
  int         error_cnt = 0;
  int         num_checks = 0;
  int         cyc       = 0;
  int         per       = 0;
  int         hi_edges  = 0;
  int         exp_edges = 0;
  int         ticks     = 0;

  always #2 i_ref_clk = ~i_ref_clk;
  // Open drain with pull-up
  assign sda_w = sda_oe ? sda_o : (pull ? 1'b0 : 1'b1);

  twi_master #(
    .QTR_STD  (QS),
    .QTR_FAST (QF)
  ) i_dut (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_fast      (fast),
    .i_cmd_valid (valid),
    .i_cmd_code  (code),
    .i_cmd_wdata (wdata),
    .i_cmd_nack  (nack),
    .o_cmd_ready (ready),
    .o_rsp_valid (rsp_valid),
    .o_rsp_data  (rsp_data),
    .o_rsp_nack  (rsp_nack),
    .o_bus_free  (bus_free),
    .o_scl       (scl),
    .o_sda_o     (sda_o),
    .o_sda_oe    (sda_oe),
    .i_sda_i     (sda_w)
  );

  twi_slave_model #(.DEV_ADDR(DEV)) i_slave (.i_scl(scl), .i_sda(sda_w), .o_pull(pull));

  ////////////////////////////////////////////////////////////////////////////
  // Clock-period meter and timeout
  always @(posedge i_ref_clk) begin
    cyc++;
    if (scl === 1'b1 && scl_q === 1'b0) begin
      per = cyc;
      cyc = 0;
    end
    scl_q = scl;
    ticks++;
    if (ticks == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // Any data change while the clock is high must be a start or a stop
  always @(sda_w) if (scl === 1'b1 && i_sys_rst === 1'b0) hi_edges++;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Held for one clock, then wait for idle again under a bound
  task automatic do_cmd(input cmd_t c, input logic [7:0] d, input logic nk);
    int n;
    n = 0;
    valid = 1'b1;
    code = c;
    wdata = d;
    nack = nk;
    @(posedge i_ref_clk);
    #1;
    valid = 1'b0;
    do begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end while (ready !== 1'b1 && n < 4000);
    if (c == CMD_START || c == CMD_STOP) begin
      // Pins lag the state by one cycle; let them settle before any look
      exp_edges++;
      @(posedge i_ref_clk);
      #1;
    end else begin
      check({7'h0, rsp_valid}, 8'h01);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    check({1'b0, scl, sda_oe, sda_o, ready, rsp_valid, rsp_nack, bus_free}, 8'h49);
  endtask

  task automatic t_write_fast;
    fast = 1'b1;
    do_cmd(CMD_START, 8'h00, 1'b0);
    check({6'h0, bus_free, scl}, 8'h00);
    do_cmd(CMD_WRITE, {DEV, 1'b0}, 1'b0);
    check({7'h0, rsp_nack}, 8'h00);
    do_cmd(CMD_WRITE, 8'h10, 1'b0);
    check({7'h0, rsp_nack}, 8'h00);
    do_cmd(CMD_WRITE, 8'ha5, 1'b0);
    do_cmd(CMD_WRITE, 8'h3c, 1'b0);
    check({7'h0, rsp_nack}, 8'h00);
    check(8'(per), 8'(4 * QF));
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    check({5'h0, bus_free, scl, sda_oe}, 8'h06);
    check(i_slave.mem[8'h10], 8'ha5);
    check(i_slave.mem[8'h11], 8'h3c);
  endtask

  task automatic t_read_std;
    fast = 1'b0;
    do_cmd(CMD_START, 8'h00, 1'b0);
    do_cmd(CMD_WRITE, {DEV, 1'b0}, 1'b0);
    do_cmd(CMD_WRITE, 8'h10, 1'b0);
    do_cmd(CMD_START, 8'h00, 1'b0);
    do_cmd(CMD_WRITE, {DEV, 1'b1}, 1'b0);
    check({7'h0, rsp_nack}, 8'h00);
    do_cmd(CMD_READ, 8'h00, 1'b0);
    check(rsp_data, 8'ha5);
    check({7'h0, i_slave.ack_seen}, 8'h00);
    do_cmd(CMD_READ, 8'h00, 1'b1);
    check(rsp_data, 8'h3c);
    check({7'h0, i_slave.ack_seen}, 8'h01);
    check(8'(per), 8'(4 * QS));
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    check({7'h0, bus_free}, 8'h01);
  endtask

  task automatic t_bad_addr;
    do_cmd(CMD_START, 8'h00, 1'b0);
    do_cmd(CMD_WRITE, 8'h46, 1'b0);
    check({7'h0, rsp_nack}, 8'h01);
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    check({6'h0, bus_free, sda_oe}, 8'h02);
  endtask

  task automatic report_and_stop;
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge i_ref_clk);
    #1;
    i_sys_rst = 1'b0;
    t_reset();
    t_write_fast();
    t_read_std();
    t_bad_addr();
    check(8'(hi_edges), 8'(exp_edges));
    report_and_stop();
  end
endmodule
